// >>> config_space_write_lock_defs.svh
`ifndef CONFIG_SPACE_WRITE_LOCK_DEFS_SVH
`define CONFIG_SPACE_WRITE_LOCK_DEFS_SVH

// Number of guarded regions, one lock word each
`define CSL_NUM_REGIONS 5
// Word index of the first lock word; the five lock words are consecutive
`define CSL_LOCK_BASE 6'h00
// Word index of the first guarded region and the span of each region
`define CSL_REGION_BASE 6'h08
`define CSL_REGION_SPAN 6'h08
// Lock state after reset, bit 0 for region 1
`define CSL_LOCK_RESET 5'h00
// Reset value of every stored configuration word
`define CSL_WORD_RESET 32'h0000_0000
// Region 5 keys
`define CSL_R5_LOCK_KEY 32'h143F832C
`define CSL_R5_UNLOCK_KEY 32'h6F361E05
// Keys of regions 1 to 4, plain defaults
`define CSL_R4_LOCK_KEY 32'hA5A50004
`define CSL_R3_LOCK_KEY 32'hA5A50003
`define CSL_R2_LOCK_KEY 32'hA5A50002
`define CSL_R1_LOCK_KEY 32'hA5A50001
`define CSL_R4_UNLOCK_KEY 32'h5A5A0004
`define CSL_R3_UNLOCK_KEY 32'h5A5A0003
`define CSL_R2_UNLOCK_KEY 32'h5A5A0002
`define CSL_R1_UNLOCK_KEY 32'h5A5A0001

`endif

// >>> csl_pkg.sv
package csl_pkg;
   // Whole-space access state; blocked is left only by reset
   typedef enum logic {ACCESS_OPEN, ACCESS_BLOCKED} access_state_t;
   typedef logic [31:0] word_t;
endpackage

// >>> config_space_write_lock.sv
// What this block and its master do
// [RULE1] Five lock words, each guarding its own region of the control space.
// [RULE2] Writes into a locked region are dropped; stored contents stay unchanged.
// [RULE3] Lock word locks on its lock key, unlocks on its unlock key.
// [RULE4] Region 5 locks when its lock word receives 0x143F832C.
// [RULE5] Region 5 unlocks when its lock word receives 0x6F361E05.
// [RULE6] Reading region 5 lock word while locked returns the lock key.
// [RULE7] Write into locked region 5 answers with a bus error.
// [RULE8] After that error the whole space stays blocked until reset.
// [RULE9] Master reads region 5 lock word and unlocks before changing pads.
// [RULE10] Master updates pad words, then relocks region 5 with the lock key.
// [RULE11] Master never writes region 5 pad words while region 5 is locked.
// [RULE12] Other values written to a lock word leave its state unchanged.
`include "config_space_write_lock_defs.svh"

module config_space_write_lock
   import csl_pkg::*;
#(
   parameter int ADDR_W = 6,
   parameter logic [4:0][31:0] LOCK_KEYS = {`CSL_R5_LOCK_KEY, `CSL_R4_LOCK_KEY,
      `CSL_R3_LOCK_KEY, `CSL_R2_LOCK_KEY, `CSL_R1_LOCK_KEY},
   parameter logic [4:0][31:0] UNLOCK_KEYS = {`CSL_R5_UNLOCK_KEY, `CSL_R4_UNLOCK_KEY,
      `CSL_R3_UNLOCK_KEY, `CSL_R2_UNLOCK_KEY, `CSL_R1_UNLOCK_KEY}
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic [ADDR_W-1:0] reqAddr,
   input wire logic [31:0] reqWdata,
   output logic rspValid,
   output logic rspErr,
   output logic [31:0] rspRdata,
   output logic [4:0] lockState,
   output logic accessBlocked
);

   // Address map, in words: lock words 0 to 4 guard regions 1 to 5,
   // region k spans 8k to 8k+7, and every other word is plain storage.
   // Lock words read back as the key that last took effect.
   // A locked write to regions 1 to 4 vanishes quietly; one to region 5
   // errors and shuts the whole space until reset, so software must
   // unlock region 5 before touching it.
   localparam int NUM_WORDS = 2 ** ADDR_W;

   // The map needs room for the lock words and all five regions
   if (ADDR_W < 6 || ADDR_W > 12)
   begin : g_check
      $error("ADDR_W must lie between 6 and 12");
   end

   // Guarded regions must sit inside the addressable words
   if (int'(`CSL_REGION_BASE) + `CSL_NUM_REGIONS * int'(`CSL_REGION_SPAN) > NUM_WORDS)
   begin : g_map
      $error("Guarded regions do not fit the address space");
   end

   // Equal keys would let one value both lock and unlock a region
   for (genvar k = 0; k < `CSL_NUM_REGIONS; k++)
   begin : g_keys
      if (LOCK_KEYS[k] == UNLOCK_KEYS[k])
      begin : g_same
         $error("Lock and unlock keys of a region must differ");
      end
   end

   // Whole-space state and the lock bits
   access_state_t state_ff;
   access_state_t nxt_state;
   logic blocked_ff;
   logic [4:0] lock_ff;

   // Answer registers and the stored words
   logic rspValid_ff;
   logic rspErr_ff;
   word_t rspRdata_ff;
   word_t nxt_rdata;
   word_t mem [0:NUM_WORDS-1];

   // Request decode, settled every cycle
   logic [2:0] lockIdx;
   logic [2:0] regionIdx;
   logic wrReq;
   logic open;
   logic regionLocked;
   logic hit5Locked;
   logic memWrite;

   // Which lock word an address names: 0 for none, else region number
   function automatic logic [2:0] lockRegOf(input logic [ADDR_W-1:0] a);
      int idx;
      idx = int'(a) - int'(`CSL_LOCK_BASE);
      if (idx >= 0 && idx < `CSL_NUM_REGIONS)
         lockRegOf = 3'(idx + 1);
      else
         lockRegOf = 3'h0;
   endfunction

   // Which guarded region an address falls in: 0 for none
   function automatic logic [2:0] regionOf(input logic [ADDR_W-1:0] a);
      int idx;
      idx = int'(a) - int'(`CSL_REGION_BASE);
      if (idx >= 0 && idx < `CSL_NUM_REGIONS * int'(`CSL_REGION_SPAN))
         regionOf = 3'(idx / int'(`CSL_REGION_SPAN) + 1);
      else
         regionOf = 3'h0;
   endfunction

   // Request decode
   always_comb
   begin
      // Zero from either decoder means the address is not of that kind
      lockIdx = lockRegOf(reqAddr); // RULE1
      regionIdx = regionOf(reqAddr); // RULE1
      wrReq = reqValid & reqWrite;
      open = (state_ff == ACCESS_OPEN);
      regionLocked = (regionIdx != 3'h0) && lock_ff[regionIdx - 3'h1];
      // Region 5 differs: a locked write is an error, not a quiet drop
      hit5Locked = wrReq & open & (regionIdx == 3'h5) & lock_ff[4]; // RULE7
      // Lock words are never guarded themselves, so a locked region can be reopened while the space is open
      memWrite = wrReq & open & (lockIdx == 3'h0) & ~regionLocked; // RULE2
   end

   // Whole-space blocking; only reset reopens the space
   always_comb
   begin
      case (state_ff)
         ACCESS_OPEN: nxt_state = hit5Locked ? ACCESS_BLOCKED : ACCESS_OPEN; // RULE8
         ACCESS_BLOCKED: nxt_state = ACCESS_BLOCKED; // RULE8
         // Unknown codes fall to blocked, the safe side
         default: nxt_state = ACCESS_BLOCKED;
      endcase
   end

   // Blocked flag sits beside the state so its output leaves a flop directly
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         state_ff <= ACCESS_OPEN;
         blocked_ff <= 1'b0;
      end
      else if (ce)
      begin
         state_ff <= nxt_state;
         blocked_ff <= (nxt_state == ACCESS_BLOCKED);
      end
   end

   // Lock words; keys compared on the full 32 bits
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         lock_ff <= `CSL_LOCK_RESET;
      else if (ce && wrReq && open && lockIdx != 3'h0)
      begin
         // A stray value leaves the bit alone, so bus noise cannot unlock a region
         if (reqWdata == LOCK_KEYS[lockIdx - 3'h1])
            lock_ff[lockIdx - 3'h1] <= 1'b1; // RULE3 RULE4
         else if (reqWdata == UNLOCK_KEYS[lockIdx - 3'h1])
            lock_ff[lockIdx - 3'h1] <= 1'b0; // RULE3 RULE5
         else
            lock_ff <= lock_ff; // RULE12
      end
   end

   // Configuration storage; lock-word slots are never written here
   // Clearing every word costs a wide reset but keeps untouched reads defined
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         for (int i = 0; i < NUM_WORDS; i++)
            mem[i] <= `CSL_WORD_RESET;
      end
      else if (ce && memWrite)
         mem[reqAddr] <= reqWdata; // RULE2
   end

   // Read data; a blocked space returns zero so nothing leaks out
   // Reads of a locked region stay open: only writes are guarded
   always_comb
   begin
      nxt_rdata = 32'h0000_0000;
      if (reqValid && !reqWrite && open)
      begin
         if (lockIdx != 3'h0)
            nxt_rdata = lock_ff[lockIdx - 3'h1] ? LOCK_KEYS[lockIdx - 3'h1] // RULE6
                                                : UNLOCK_KEYS[lockIdx - 3'h1];
         else
            nxt_rdata = mem[reqAddr];
      end
   end

   // Answer one cycle after each request
   // With ce low the answer is frozen and stands until the next enabled edge
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         rspValid_ff <= 1'b0;
         rspErr_ff <= 1'b0;
         rspRdata_ff <= 32'h0000_0000;
      end
      else if (ce)
      begin
         rspValid_ff <= reqValid;
         // Errors cover the region 5 trap and every access once blocked
         rspErr_ff <= reqValid & (~open | hit5Locked); // RULE7 RULE8
         rspRdata_ff <= nxt_rdata;
      end
   end

   // Every output straight from a flop
   assign rspValid = rspValid_ff;
   assign rspErr = rspErr_ff;
   assign rspRdata = rspRdata_ff;
   assign lockState = lock_ff;
   assign accessBlocked = blocked_ff;

endmodule

// >>> csl_checker_sva.sv
module csl_checker
   import csl_pkg::*;
#(parameter int ADDR_W = 6)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic [ADDR_W-1:0] reqAddr,
   input wire logic [31:0] reqWdata,
   input wire logic rspValid,
   input wire logic rspErr,
   input wire logic [31:0] rspRdata,
   input wire logic [4:0] lockState,
   input wire logic accessBlocked
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   logic wr;
   // Writes that the open space still honours
   assign wr = ce && reqValid && reqWrite && !accessBlocked;
   AST_R5_LOCK: assert property (wr && reqAddr == 4 && reqWdata == 32'h143F832C
      |=> lockState[4]) else $error("r5 lock");
   AST_R5_OPEN: assert property (wr && reqAddr == 4 && reqWdata == 32'h6F361E05
      |=> !lockState[4]) else $error("r5 unlock");
   AST_R5_READ: assert property (ce && reqValid && !reqWrite && reqAddr == 4
      && lockState[4] && !accessBlocked |=> rspRdata == 32'h143F832C) else $error("r5 read");
   AST_R5_ERR: assert property (wr && reqAddr >= 40 && reqAddr < 48 && lockState[4]
      |=> rspValid && rspErr && accessBlocked) else $error("r5 error");
   AST_STAYS: assert property (accessBlocked |=> accessBlocked && $stable(lockState))
      else $error("block lost");
   AST_QUIET: assert property (wr && reqAddr >= 8 && reqAddr < 40
      && lockState[reqAddr[5:3]-3'h1] |=> rspValid && !rspErr) else $error("quiet drop");
   AST_JUNK: assert property (wr && reqAddr == 4 && reqWdata != 32'h143F832C
      && reqWdata != 32'h6F361E05 |=> $stable(lockState)) else $error("junk key");
   AST_OWN: assert property (!(wr && reqAddr < 5) |=> $stable(lockState))
      else $error("stray lock change");
   cover property (wr && reqAddr == 4 && lockState[4]);
   cover property (rspErr);
   cover property (lockState[0]);
endmodule

// >>> cfg_master.sv
`include "config_space_write_lock_defs.svh"
module cfg_master
   import csl_pkg::*;
(
   input wire logic clk,
   output logic reqValid,
   output logic reqWrite,
   output logic [5:0] reqAddr,
   output word_t reqWdata,
   input wire logic rspErr,
   input wire word_t rspRdata
);
   timeunit 1ns;
   timeprecision 100ps;
   initial reqValid = 1'b0;
   // One transfer; answer lands on the same edge that takes it
   task automatic acc(input logic w, input logic [5:0] a, input word_t d,
      output logic e, output word_t r);
      @(posedge clk);
      reqValid <= 1'b1;
      reqWrite <= w;
      reqAddr <= a;
      reqWdata <= d;
      @(posedge clk);
      reqValid <= 1'b0;
      reqWdata <= ~d; // No stale data left on the bus
      #1;
      e = rspErr;
      r = rspRdata;
   endtask
   // Unlock only when locked, so a locked pad word is never hit
   task automatic padUpdate(input logic [5:0] a, input word_t d);
      logic e;
      word_t r;
      acc(1'b0, 6'h04, 32'h0, e, r);
      if (r === `CSL_R5_LOCK_KEY)
         acc(1'b1, 6'h04, `CSL_R5_UNLOCK_KEY, e, r);
      acc(1'b1, a, d, e, r);
      acc(1'b1, 6'h04, `CSL_R5_LOCK_KEY, e, r);
   endtask
endmodule

// >>> config_space_write_lock_bench.sv
module config_space_write_lock_bench
   import csl_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {logic w; logic [5:0] a; word_t d; logic e; word_t r;} row_t;
   logic clk, reset, ce, reqValid, reqWrite, rspValid, rspErr, accessBlocked, e;
   logic [5:0] reqAddr;
   logic [4:0] lockState;
   word_t reqWdata, rspRdata, r;
   int numErrors = 0, nCompared = 0, cyc = 0;
   // Write, address, data, expected error, expected read data
   row_t rows[9] = '{'{1'b0, 6'h04, 32'h0, 1'b0, 32'h6F361E05},
      '{1'b1, 6'h28, 32'h11, 1'b0, 32'h0}, '{1'b1, 6'h04, 32'h143F832C, 1'b0, 32'h0},
      '{1'b1, 6'h04, 32'h0BAD, 1'b0, 32'h0}, '{1'b0, 6'h04, 32'h0, 1'b0, 32'h143F832C},
      '{1'b1, 6'h00, 32'hA5A50001, 1'b0, 32'h0},
      '{1'b1, 6'h00, 32'h1234, 1'b0, 32'h0}, '{1'b1, 6'h08, 32'h33, 1'b0, 32'h0},
      '{1'b0, 6'h08, 32'h0, 1'b0, 32'h0}};
   config_space_write_lock DUT (.clk, .reset, .ce, .reqValid, .reqWrite, .reqAddr,
      .reqWdata, .rspValid, .rspErr, .rspRdata, .lockState, .accessBlocked);
   cfg_master master (.clk, .reqValid, .reqWrite, .reqAddr, .reqWdata, .rspErr, .rspRdata);
   task automatic chk(input logic ok);
      nCompared++;
      if (ok !== 1'b1)
      begin
         numErrors++;
         $display("[FAIL] %0t ns mismatch", $time);
      end
   endtask
   task automatic stopTest();
      $display("errors %0d compared %0d", numErrors, nCompared);
      if (numErrors == 0 && nCompared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Hang guard, far above the roughly 62 cycles needed
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         numErrors++;
         stopTest();
      end
   end
   initial
   begin
      reset = 1'b1;
      ce = 1'b1;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      chk(lockState === 5'h00 && accessBlocked === 1'b0);
      foreach (rows[i])
      begin
         master.acc(rows[i].w, rows[i].a, rows[i].d, e, r);
         chk(e === rows[i].e && r === rows[i].r);
      end
      chk(lockState === 5'h11);
      $display("table done");
      @(posedge clk) ce <= 1'b0;
      master.acc(1'b1, 6'h04, 32'h6F361E05, e, r);
      chk(lockState === 5'h11);
      @(posedge clk) ce <= 1'b1;
      $display("hold done");
      master.padUpdate(6'h29, 32'h55);
      master.acc(1'b0, 6'h29, 32'h0, e, r);
      chk(r === 32'h55 && lockState === 5'h11);
      $display("pad update done");
      master.acc(1'b1, 6'h2A, 32'h66, e, r);
      chk(e === 1'b1 && accessBlocked === 1'b1);
      master.acc(1'b1, 6'h04, 32'h6F361E05, e, r);
      chk(e === 1'b1 && lockState === 5'h11);
      master.acc(1'b0, 6'h29, 32'h0, e, r);
      chk(e === 1'b1 && r === 32'h0);
      $display("block done");
      @(posedge clk);
      reset <= 1'b1;
      @(posedge clk);
      reset <= 1'b0;
      #1;
      chk(accessBlocked === 1'b0 && lockState === 5'h00);
      master.acc(1'b0, 6'h29, 32'h0, e, r);
      chk(e === 1'b0 && r === 32'h0);
      $display("reset done");
      stopTest();
   end
endmodule
bind config_space_write_lock csl_checker #(.ADDR_W(ADDR_W)) uChk (.clk, .reset, .ce,
   .reqValid, .reqWrite, .reqAddr, .reqWdata, .rspValid, .rspErr, .rspRdata, .lockState,
   .accessBlocked);
